// file: hw/pscr_pkg.sv
package pscr_pkg;

	localparam int unsigned ADDR_W = 9;
	localparam int unsigned DATA_W = 8;

	// register offsets
	localparam logic [8:0] OFS_REF_PATH_CTRL          = 9'h0_22;
	localparam logic [8:0] OFS_OSC_OUTPUT_LEVEL       = 9'h0_25;
	localparam logic [8:0] OFS_PUMP_BLEED_MAGNITUDE   = 9'h0_26;
	localparam logic [8:0] OFS_LOCK_WINDOW_BLEED_CTRL = 9'h0_27;
	localparam logic [8:0] OFS_LOCK_COUNT_CTRL        = 9'h0_28;
	localparam logic [8:0] OFS_BLEED_POLARITY_SYNC    = 9'h0_2a;
	localparam logic [8:0] OFS_MODULATOR_CTRL         = 9'h0_2b;
	localparam logic [8:0] OFS_LEVEL_LOOP_CTRL        = 9'h0_2c;
	localparam logic [8:0] OFS_BAND_SELECT_DIVIDER    = 9'h0_30;
	localparam logic [8:0] OFS_CAL_WAIT_LOW           = 9'h0_31;
	localparam logic [8:0] OFS_CAL_ADC_CTRL           = 9'h0_32;
	localparam logic [8:0] OFS_READBACK_SEL_LOCK_WAIT = 9'h0_33;
	localparam logic [8:0] OFS_CAL_TEST_MODE          = 9'h0_34;

	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	// field positions
	localparam int unsigned BIT_REF_DOUBLER   = 5;
	localparam int unsigned BIT_REF_HALVER    = 4;
	localparam int unsigned BIT_LOCK_PREC     = 5;
	localparam int unsigned BIT_GATED_OFFSET  = 4;
	localparam int unsigned BIT_OFFSET_ON     = 3;
	localparam int unsigned BIT_OSC_PD        = 2;
	localparam int unsigned BIT_LOCK_LOSS_ON  = 0;
	localparam int unsigned BIT_OFFSET_POL    = 5;
	localparam int unsigned BIT_SEL_REF_ALIGN = 3;
	localparam int unsigned BIT_HALF_LSB      = 5;
	localparam int unsigned BIT_AUX_MOD       = 4;
	localparam int unsigned BIT_MASK_CLR      = 2;
	localparam int unsigned BIT_MOD_PD        = 0;
	localparam int unsigned BIT_LEVEL_OFF     = 0;
	localparam int unsigned BIT_ADC_INPUT     = 7;
	localparam int unsigned BIT_ADC_FAST      = 5;
	localparam int unsigned BIT_ADC_CONT      = 4;
	localparam int unsigned BIT_ADC_CONV      = 3;
	localparam int unsigned BIT_ADC_EN        = 2;

	// multi-bit field bounds
	localparam int unsigned FLD_LEVEL_HI   = 1;
	localparam int unsigned FLD_LEVEL_LO   = 0;
	localparam int unsigned FLD_WIN_HI     = 7;
	localparam int unsigned FLD_WIN_LO     = 6;
	localparam int unsigned FLD_CNT_HI     = 2;
	localparam int unsigned FLD_CNT_LO     = 1;
	localparam int unsigned FLD_WAIT_UP_HI = 1;
	localparam int unsigned FLD_WAIT_UP_LO = 0;
	localparam int unsigned FLD_VIEW_HI    = 7;
	localparam int unsigned FLD_VIEW_LO    = 5;
	localparam int unsigned FLD_LWAIT_HI   = 4;
	localparam int unsigned FLD_LWAIT_LO   = 0;
	localparam int unsigned FLD_TEST_HI    = 7;
	localparam int unsigned FLD_TEST_LO    = 5;

	// lock window codes in ns
	localparam logic [3:0] WIN_NS_0 = 4'h5;
	localparam logic [3:0] WIN_NS_1 = 4'h6;
	localparam logic [3:0] WIN_NS_2 = 4'h8;
	localparam logic [3:0] WIN_NS_3 = 4'hc;
	// precision in tenths of ns
	localparam logic [5:0] PREC_FRAC_TENTHS = 6'h32;
	localparam logic [5:0] PREC_INT_TENTHS  = 6'h18;

	// lock counts in phase detector cycles
	localparam logic [13:0] LOCK_CNT_0 = 14'h0400;
	localparam logic [13:0] LOCK_CNT_1 = 14'h0800;
	localparam logic [13:0] LOCK_CNT_2 = 14'h1000;
	localparam logic [13:0] LOCK_CNT_3 = 14'h2000;

	localparam logic [1:0] LEVEL_MIN = 2'h0;
	localparam logic [1:0] LEVEL_MAX = 2'h3;

	localparam logic [2:0] VIEW_CHECKER  = 3'h0;
	localparam logic [2:0] VIEW_CORE     = 3'h1;
	localparam logic [2:0] VIEW_TEMP_ADC = 3'h5;
	localparam logic [7:0] CHECKER_PAT   = 8'h55;

	localparam logic [2:0] TEST_NORMAL   = 3'h0;
	localparam logic [2:0] TEST_CORE_OVR = 3'h2;
	localparam logic [2:0] TEST_VCAL_OVR = 3'h4;

	typedef enum logic [1:0] {
		PSCR_HUNT   = 2'b00,
		PSCR_LOCKED = 2'b01
	} pscr_lock_t;

	typedef struct packed {
		logic       wr;
		logic [8:0] addr;
		logic [7:0] wdata;
	} pscr_wr_t;

	typedef struct packed {
		logic       ref_doubler_on;
		logic       ref_halver_on;
		logic [1:0] osc_level_select;
		logic       osc_powerdown;
		logic [8:0] pump_offset;
		logic       pump_offset_active;
		logic [3:0] lock_window_ns;
		logic [5:0] lock_precision_tenths;
		logic       half_lsb_add;
		logic       modulator_powerdown;
		logic       modulator_mask_clear;
		logic       level_loop_on;
		logic [7:0] band_select_divider;
		logic [9:0] cal_wait_limit;
		logic [4:0] synth_lock_wait;
		logic       adc_input_tuning;
		logic       adc_enable;
		logic       adc_convert;
		logic       adc_continuous;
		logic       adc_fast;
		logic       core_override;
		logic       vcal_override;
		logic       ref_aligned_update;
	} pscr_ctrl_t;

endpackage

// file: hw/pscr_regs.sv
////////////////////////////////////////////////////////////////////////////
module pscr_regs
(
	input  wire logic                 i_clock,
	input  wire logic                 i_rst_b,
	input  wire pscr_pkg::pscr_wr_t   i_wr,
	input  wire logic [8:0]           i_rd_addr,
	input  wire logic                 i_pfd_tick,
	input  wire logic                 i_in_window,
	input  wire logic                 i_ref_present,
	input  wire logic                 i_ref_edge,
	input  wire logic                 i_int_word_update,
	input  wire logic [7:0]           i_core_band,
	input  wire logic [7:0]           i_temp_adc,
	output logic [7:0]                o_rd_data,
	output logic [7:0]                o_fsm_view,
	output logic                      o_lock,
	output logic                      o_update_strobe,
	output pscr_pkg::pscr_ctrl_t      o_ctrl
);
	import pscr_pkg::*;

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [7:0]  ref_path;
		logic [7:0]  osc_level;
		logic [7:0]  bleed_mag;
		logic [7:0]  lock_win;
		logic [7:0]  lock_cnt;
		logic [7:0]  bleed_pol;
		logic [7:0]  modulator;
		logic [7:0]  level_loop;
		logic [7:0]  band_div;
		logic [7:0]  wait_low;
		logic [7:0]  adc_ctrl;
		logic [7:0]  view_wait;
		logic [7:0]  test_mode;
		logic [7:0]  rd_data;
		logic [7:0]  fsm_view;
		logic [13:0] good_cnt;
		pscr_lock_t  lock_st;
		logic        lock;
		logic        upd_pend;
		logic        upd_strobe;
		logic        mask_clr;
		pscr_ctrl_t  ctrl;
	} pscr_state_t;

	pscr_state_t s_q;
	pscr_state_t s_d;
	logic [13:0] lock_target;

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		s_d = s_q;
		s_d.upd_strobe = 1'b0;
		s_d.mask_clr = 1'b0;
		// plain register writes; a write to OFS_CAL_TEST_MODE also arms the update below
		if (i_wr.wr)
		begin
			unique case (i_wr.addr)
				OFS_REF_PATH_CTRL:          s_d.ref_path   = i_wr.wdata;
				OFS_OSC_OUTPUT_LEVEL:       s_d.osc_level  = i_wr.wdata;
				OFS_PUMP_BLEED_MAGNITUDE:   s_d.bleed_mag  = i_wr.wdata;
				OFS_LOCK_WINDOW_BLEED_CTRL: s_d.lock_win   = i_wr.wdata;
				OFS_LOCK_COUNT_CTRL:        s_d.lock_cnt   = i_wr.wdata;
				OFS_BLEED_POLARITY_SYNC:    s_d.bleed_pol  = i_wr.wdata;
				OFS_MODULATOR_CTRL:         s_d.modulator  = i_wr.wdata;
				OFS_LEVEL_LOOP_CTRL:        s_d.level_loop = i_wr.wdata;
				OFS_BAND_SELECT_DIVIDER:    s_d.band_div   = i_wr.wdata;
				OFS_CAL_WAIT_LOW:           s_d.wait_low   = i_wr.wdata;
				OFS_CAL_ADC_CTRL:           s_d.adc_ctrl   = i_wr.wdata;
				OFS_READBACK_SEL_LOCK_WAIT: s_d.view_wait  = i_wr.wdata;
				OFS_CAL_TEST_MODE:          s_d.test_mode  = i_wr.wdata;
				default:                    s_d.ref_path   = s_q.ref_path;
			endcase
		end
		// readback of stored values
		unique case (i_rd_addr)
			OFS_REF_PATH_CTRL:          s_d.rd_data = s_q.ref_path;
			OFS_OSC_OUTPUT_LEVEL:       s_d.rd_data = s_q.osc_level;
			OFS_PUMP_BLEED_MAGNITUDE:   s_d.rd_data = s_q.bleed_mag;
			OFS_LOCK_WINDOW_BLEED_CTRL: s_d.rd_data = s_q.lock_win;
			OFS_LOCK_COUNT_CTRL:        s_d.rd_data = s_q.lock_cnt;
			OFS_BLEED_POLARITY_SYNC:    s_d.rd_data = s_q.bleed_pol;
			OFS_MODULATOR_CTRL:         s_d.rd_data = s_q.modulator;
			OFS_LEVEL_LOOP_CTRL:        s_d.rd_data = s_q.level_loop;
			OFS_BAND_SELECT_DIVIDER:    s_d.rd_data = s_q.band_div;
			OFS_CAL_WAIT_LOW:           s_d.rd_data = s_q.wait_low;
			OFS_CAL_ADC_CTRL:           s_d.rd_data = s_q.adc_ctrl;
			OFS_READBACK_SEL_LOCK_WAIT: s_d.rd_data = s_q.view_wait;
			OFS_CAL_TEST_MODE:          s_d.rd_data = s_q.test_mode;
			default:                    s_d.rd_data = RD_UNMAPPED;
		endcase

		// oscillator state machine readback view
		unique case (s_q.view_wait[FLD_VIEW_HI:FLD_VIEW_LO])
			VIEW_CORE:     s_d.fsm_view = i_core_band;
			VIEW_TEMP_ADC: s_d.fsm_view = i_temp_adc;
			default:       s_d.fsm_view = CHECKER_PAT;
		endcase

		// digital lock detector
		unique case (s_q.lock_st)
			PSCR_HUNT:
			begin
				if (i_pfd_tick)
				begin
					if (!i_in_window)
						s_d.good_cnt = '0;
					else if (s_q.good_cnt + 14'h0001 >= lock_target)
					begin
						s_d.lock_st = PSCR_LOCKED;
						s_d.lock = 1'b1;
						s_d.good_cnt = '0;
					end
					else
						s_d.good_cnt = s_q.good_cnt + 14'h0001;
				end
			end
			PSCR_LOCKED:
			begin
				// drop on lost reference only when enabled
				if (s_q.lock_cnt[BIT_LOCK_LOSS_ON] && !i_ref_present)
				begin
					s_d.lock_st = PSCR_HUNT;
					s_d.lock = 1'b0;
				end
				else if (i_pfd_tick && !i_in_window)
				begin
					s_d.lock_st = PSCR_HUNT;
					s_d.lock = 1'b0;
				end
			end
			default:
			begin
				s_d.lock_st = PSCR_HUNT;
				s_d.lock = 1'b0;
			end
		endcase

		// update event, optionally aligned to reference
		if (s_q.upd_pend
		    && (!s_q.bleed_pol[BIT_SEL_REF_ALIGN] || i_ref_edge))
		begin
			s_d.upd_strobe = 1'b1;
			s_d.upd_pend = 1'b0;
		end
		// new arm in the release cycle survives
		if (i_wr.wr && i_wr.addr == OFS_CAL_TEST_MODE)
			s_d.upd_pend = 1'b1;

		// mask clear pulse on integer word update
		s_d.mask_clr = i_int_word_update
		               && s_q.modulator[BIT_MASK_CLR];

		// control outputs
		s_d.ctrl.ref_doubler_on = s_q.ref_path[BIT_REF_DOUBLER];
		s_d.ctrl.ref_halver_on  = s_q.ref_path[BIT_REF_HALVER];
		s_d.ctrl.osc_level_select =
			s_q.osc_level[FLD_LEVEL_HI:FLD_LEVEL_LO];
		s_d.ctrl.osc_powerdown = s_q.lock_win[BIT_OSC_PD];
		s_d.ctrl.pump_offset_active =
			s_q.lock_win[BIT_OFFSET_ON]
			&& (!s_q.lock_win[BIT_GATED_OFFSET] || s_q.lock);
		// sign bit: 1 negative, 0 positive
		s_d.ctrl.pump_offset = s_d.ctrl.pump_offset_active
			? {!s_q.bleed_pol[BIT_OFFSET_POL], s_q.bleed_mag}
			: 9'h0_00;
		unique case (s_q.lock_win[FLD_WIN_HI:FLD_WIN_LO])
			2'b00:   s_d.ctrl.lock_window_ns = WIN_NS_0;
			2'b01:   s_d.ctrl.lock_window_ns = WIN_NS_1;
			2'b10:   s_d.ctrl.lock_window_ns = WIN_NS_2;
			default: s_d.ctrl.lock_window_ns = WIN_NS_3;
		endcase
		s_d.ctrl.lock_precision_tenths = s_q.lock_win[BIT_LOCK_PREC]
			? PREC_INT_TENTHS : PREC_FRAC_TENTHS;
		s_d.ctrl.half_lsb_add = s_q.modulator[BIT_HALF_LSB]
			&& !s_q.modulator[BIT_AUX_MOD];
		s_d.ctrl.modulator_powerdown = s_q.modulator[BIT_MOD_PD];
		s_d.ctrl.modulator_mask_clear = s_q.mask_clr;
		s_d.ctrl.level_loop_on = !s_q.level_loop[BIT_LEVEL_OFF];
		s_d.ctrl.band_select_divider = s_q.band_div;
		s_d.ctrl.cal_wait_limit =
			{s_q.adc_ctrl[FLD_WAIT_UP_HI:FLD_WAIT_UP_LO], s_q.wait_low};
		s_d.ctrl.synth_lock_wait =
			s_q.view_wait[FLD_LWAIT_HI:FLD_LWAIT_LO];
		s_d.ctrl.adc_input_tuning = s_q.adc_ctrl[BIT_ADC_INPUT];
		s_d.ctrl.adc_enable     = s_q.adc_ctrl[BIT_ADC_EN];
		s_d.ctrl.adc_convert    = s_q.adc_ctrl[BIT_ADC_CONV];
		s_d.ctrl.adc_continuous = s_q.adc_ctrl[BIT_ADC_CONT];
		s_d.ctrl.adc_fast       = s_q.adc_ctrl[BIT_ADC_FAST];
		s_d.ctrl.core_override =
			s_q.test_mode[FLD_TEST_HI:FLD_TEST_LO] == TEST_CORE_OVR;
		s_d.ctrl.vcal_override =
			s_q.test_mode[FLD_TEST_HI:FLD_TEST_LO] == TEST_VCAL_OVR;
		s_d.ctrl.ref_aligned_update = s_q.upd_strobe;
	end

	always_comb
	begin
		unique case (s_q.lock_cnt[FLD_CNT_HI:FLD_CNT_LO])
			2'b00:   lock_target = LOCK_CNT_0;
			2'b01:   lock_target = LOCK_CNT_1;
			2'b10:   lock_target = LOCK_CNT_2;
			default: lock_target = LOCK_CNT_3;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign o_rd_data       = s_q.rd_data;
	assign o_fsm_view      = s_q.fsm_view;
	assign o_lock          = s_q.lock;
	assign o_update_strobe = s_q.upd_strobe;
	assign o_ctrl          = s_q.ctrl;

	////////////////////////////////////////////////////////////////////////
	property p_doubler;
		@(posedge i_clock) disable iff (!i_rst_b)
		i_wr.wr && i_wr.addr == OFS_REF_PATH_CTRL
		|=> ##1 o_ctrl.ref_doubler_on == $past(i_wr.wdata[BIT_REF_DOUBLER], 2);
	endproperty
	a_doubler: assert property (p_doubler)
		else $error("doubler control mismatch");

	property p_bleed_gate;
		@(posedge i_clock) disable iff (!i_rst_b)
		!s_q.lock_win[BIT_OFFSET_ON] |=> !o_ctrl.pump_offset_active;
	endproperty
	a_bleed_gate: assert property (p_bleed_gate)
		else $error("bleed active while disabled");

	property p_window;
		@(posedge i_clock) disable iff (!i_rst_b)
		s_q.lock_win[FLD_WIN_HI:FLD_WIN_LO] == 2'b11
		&& $stable(s_q.lock_win)
		|=> o_ctrl.lock_window_ns == WIN_NS_3;
	endproperty
	a_window: assert property (p_window)
		else $error("lock window code wrong");

	property p_osc_pd;
		@(posedge i_clock) disable iff (!i_rst_b)
		$rose(s_q.lock_win[BIT_OSC_PD]) |=> o_ctrl.osc_powerdown;
	endproperty
	a_osc_pd: assert property (p_osc_pd)
		else $error("oscillator power down late");

	property p_lock_rise;
		@(posedge i_clock) disable iff (!i_rst_b)
		$rose(o_lock) |-> $past(i_pfd_tick) && $past(i_in_window);
	endproperty
	a_lock_rise: assert property (p_lock_rise)
		else $error("lock rose without good cycle");

	property p_lock_loss;
		@(posedge i_clock) disable iff (!i_rst_b)
		o_lock && s_q.lock_cnt[BIT_LOCK_LOSS_ON] && !i_ref_present
		|=> !o_lock;
	endproperty
	a_lock_loss: assert property (p_lock_loss)
		else $error("lock kept after reference loss");

	property p_align;
		@(posedge i_clock) disable iff (!i_rst_b)
		o_update_strobe && $past(s_q.bleed_pol[BIT_SEL_REF_ALIGN])
		|-> $past(i_ref_edge);
	endproperty
	a_align: assert property (p_align)
		else $error("update not aligned to reference");

	property p_half_lsb;
		@(posedge i_clock) disable iff (!i_rst_b)
		s_q.modulator[BIT_AUX_MOD] |=> !o_ctrl.half_lsb_add;
	endproperty
	a_half_lsb: assert property (p_half_lsb)
		else $error("half lsb with aux modulator");

	property p_mask;
		@(posedge i_clock) disable iff (!i_rst_b)
		i_int_word_update && s_q.modulator[BIT_MASK_CLR]
		|=> ##1 o_ctrl.modulator_mask_clear;
	endproperty
	a_mask: assert property (p_mask)
		else $error("mask clear missing");

	property p_level;
		@(posedge i_clock) disable iff (!i_rst_b)
		s_q.level_loop[BIT_LEVEL_OFF] |=> !o_ctrl.level_loop_on;
	endproperty
	a_level: assert property (p_level)
		else $error("level loop not off");

	property p_wait;
		@(posedge i_clock) disable iff (!i_rst_b)
		1'b1 |=> o_ctrl.cal_wait_limit
		         == {$past(s_q.adc_ctrl[FLD_WAIT_UP_HI:FLD_WAIT_UP_LO]),
		             $past(s_q.wait_low)};
	endproperty
	a_wait: assert property (p_wait)
		else $error("wait limit assembly wrong");

	property p_view;
		@(posedge i_clock) disable iff (!i_rst_b)
		s_q.view_wait[FLD_VIEW_HI:FLD_VIEW_LO] == VIEW_CHECKER
		|=> o_fsm_view == CHECKER_PAT;
	endproperty
	a_view: assert property (p_view)
		else $error("checkerboard view wrong");

	property p_level_sel;
		@(posedge i_clock) disable iff (!i_rst_b)
		1'b1 |=> o_ctrl.osc_level_select
		         == $past(s_q.osc_level[FLD_LEVEL_HI:FLD_LEVEL_LO]);
	endproperty
	a_level_sel: assert property (p_level_sel)
		else $error("oscillator level select wrong");

	property p_precision;
		@(posedge i_clock) disable iff (!i_rst_b)
		s_q.lock_win[BIT_LOCK_PREC]
		|=> o_ctrl.lock_precision_tenths == PREC_INT_TENTHS;
	endproperty
	a_precision: assert property (p_precision)
		else $error("integer precision not selected");

	property p_polarity;
		@(posedge i_clock) disable iff (!i_rst_b)
		s_q.lock_win[BIT_OFFSET_ON] && !s_q.lock_win[BIT_GATED_OFFSET]
		&& s_q.bleed_pol[BIT_OFFSET_POL]
		|=> o_ctrl.pump_offset == {1'b0, $past(s_q.bleed_mag)};
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("positive bleed sign wrong");

	property p_adc_input;
		@(posedge i_clock) disable iff (!i_rst_b)
		1'b1 |=> o_ctrl.adc_input_tuning
		         == $past(s_q.adc_ctrl[BIT_ADC_INPUT]);
	endproperty
	a_adc_input: assert property (p_adc_input)
		else $error("adc input select wrong");

	property p_vcal;
		@(posedge i_clock) disable iff (!i_rst_b)
		s_q.test_mode[FLD_TEST_HI:FLD_TEST_LO] == TEST_VCAL_OVR
		|=> o_ctrl.vcal_override && !o_ctrl.core_override;
	endproperty
	a_vcal: assert property (p_vcal)
		else $error("voltage override mode wrong");

	property p_read;
		@(posedge i_clock) disable iff (!i_rst_b)
		i_rd_addr == OFS_MODULATOR_CTRL
		|=> o_rd_data == $past(s_q.modulator);
	endproperty
	a_read: assert property (p_read)
		else $error("read data not last written");

endmodule

// file: verification/test_pll_synth_config_regs.sv
module test_pll_synth_config_regs;
	timeunit 1ns;
	timeprecision 1ns;
	import pscr_pkg::*;

`define CHK(act, exp, msg) \
	begin \
		checked++; \
		if ((act) !== (exp)) \
		begin \
			mismatches++; \
			$display("unexpected at %0t: %s", $time, msg); \
		end \
	end

	////////////////////////////////////////////////////////////////////////
	// stimulus and observation
	logic         i_clock           = 1'b0;
	logic         i_rst_b           = 1'b0;
	pscr_wr_t     i_wr              = '0;
	logic [8:0]   i_rd_addr         = 9'h0_00;
	logic         i_pfd_tick        = 1'b0;
	logic         i_in_window       = 1'b0;
	logic         i_ref_present     = 1'b1;
	logic         i_ref_edge        = 1'b0;
	logic         i_int_word_update = 1'b0;
	logic [7:0]   i_core_band       = 8'h00;
	logic [7:0]   i_temp_adc        = 8'h00;
	logic [7:0]   o_rd_data;
	logic [7:0]   o_fsm_view;
	logic         o_lock;
	logic         o_update_strobe;
	pscr_ctrl_t   o_ctrl;
	int           mismatches = 0;
	int           checked    = 0;
	int           strobes    = 0;
	int           aligned    = 0;
	int           clears     = 0;
	logic [7:0]   mdl [logic [8:0]];
	logic [8:0]   ofs [13] = '{OFS_REF_PATH_CTRL, OFS_OSC_OUTPUT_LEVEL,
		OFS_PUMP_BLEED_MAGNITUDE, OFS_LOCK_WINDOW_BLEED_CTRL,
		OFS_LOCK_COUNT_CTRL, OFS_BLEED_POLARITY_SYNC, OFS_MODULATOR_CTRL,
		OFS_LEVEL_LOOP_CTRL, OFS_BAND_SELECT_DIVIDER, OFS_CAL_WAIT_LOW,
		OFS_CAL_ADC_CTRL, OFS_READBACK_SEL_LOCK_WAIT, OFS_CAL_TEST_MODE};

	pscr_regs u_pscr_regs (
		.i_clock               (i_clock),
		.i_rst_b               (i_rst_b),
		.i_wr                  (i_wr),
		.i_rd_addr             (i_rd_addr),
		.i_pfd_tick            (i_pfd_tick),
		.i_in_window           (i_in_window),
		.i_ref_present         (i_ref_present),
		.i_ref_edge            (i_ref_edge),
		.i_int_word_update     (i_int_word_update),
		.i_core_band           (i_core_band),
		.i_temp_adc            (i_temp_adc),
		.o_rd_data             (o_rd_data),
		.o_fsm_view            (o_fsm_view),
		.o_lock                (o_lock),
		.o_update_strobe       (o_update_strobe),
		.o_ctrl                (o_ctrl)
	);

	initial
	begin
		forever #10 i_clock = ~i_clock;
	end

	always @(posedge i_clock)
	begin
		if (o_update_strobe === 1'b1)
			strobes++;
		if (o_ctrl.ref_aligned_update === 1'b1)
			aligned++;
		if (o_ctrl.modulator_mask_clear === 1'b1)
			clears++;
	end

	////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic tick(input int n);
		repeat (n) @(negedge i_clock);
	endtask

	task automatic do_reset();
		i_rst_b <= 1'b0;
		tick(10);
		i_rst_b <= 1'b1;
		foreach (ofs[j]) mdl[ofs[j]] = 8'h00;
		tick(2);
	endtask

	task automatic wreg(input logic [8:0] a, input logic [7:0] d);
		i_wr <= '{wr: 1'b1, addr: a, wdata: d};
		tick(1);
		i_wr <= '0;
		if (mdl.exists(a))
			mdl[a] = d;
		tick(1);
	endtask

	task automatic rchk(input logic [8:0] a);
		logic [7:0] e;
		e = mdl.exists(a) ? mdl[a] : 8'h00;
		i_rd_addr <= a;
		tick(1);
		`CHK(o_rd_data, e, "read data")
	endtask

	task automatic pulse(input int n, input logic inw);
		i_in_window <= inw;
		i_pfd_tick <= 1'b1;
		tick(n);
		i_pfd_tick <= 1'b0;
		tick(1);
	endtask

	task automatic cchk();
		logic [7:0] g, v, m, w, b, md, l, t, a, q, x;
		logic [3:0] ns [4];
		ns = '{4'h5, 4'h6, 4'h8, 4'hc};
		g = mdl[OFS_REF_PATH_CTRL];
		v = mdl[OFS_OSC_OUTPUT_LEVEL];
		m = mdl[OFS_PUMP_BLEED_MAGNITUDE];
		w = mdl[OFS_LOCK_WINDOW_BLEED_CTRL];
		b = mdl[OFS_BLEED_POLARITY_SYNC];
		md = mdl[OFS_MODULATOR_CTRL];
		l = mdl[OFS_LEVEL_LOOP_CTRL];
		t = mdl[OFS_CAL_WAIT_LOW];
		a = mdl[OFS_CAL_ADC_CTRL];
		q = mdl[OFS_READBACK_SEL_LOCK_WAIT];
		x = mdl[OFS_CAL_TEST_MODE];
		tick(3);
		`CHK(o_ctrl.ref_doubler_on, g[5], "doubler")
		`CHK(o_ctrl.ref_halver_on, g[4], "halver")
		`CHK(o_ctrl.osc_level_select, v[1:0], "level")
		`CHK(o_ctrl.pump_offset_active, w[3] & ~w[4], "bleed on")
		if (w[3] & ~w[4])
			`CHK(o_ctrl.pump_offset, {~b[5], m}, "bleed")
		`CHK(o_ctrl.lock_window_ns, ns[w[7:6]], "window")
		`CHK(o_ctrl.lock_precision_tenths, w[5] ? 6'h18 : 6'h32,
			"prec")
		`CHK(o_ctrl.osc_powerdown, w[2], "osc pd")
		`CHK(o_ctrl.half_lsb_add, md[5] & ~md[4], "half lsb")
		`CHK(o_ctrl.modulator_powerdown, md[0], "mod pd")
		`CHK(o_ctrl.level_loop_on, ~l[0], "level loop")
		`CHK(o_ctrl.band_select_divider, mdl[OFS_BAND_SELECT_DIVIDER],
			"div")
		`CHK(o_ctrl.cal_wait_limit, {a[1:0], t}, "cal wait")
		`CHK(o_ctrl.synth_lock_wait, q[4:0], "lock wait")
		`CHK(o_ctrl.adc_input_tuning, a[7], "adc input")
		`CHK({o_ctrl.adc_enable, o_ctrl.adc_convert, o_ctrl.adc_continuous,
			o_ctrl.adc_fast}, {a[2], a[3], a[4], a[5]}, "adc")
		`CHK(o_ctrl.core_override, x[7:5] == 3'h2, "core ovr")
		`CHK(o_ctrl.vcal_override, x[7:5] == 3'h4, "vcal ovr")
		case (q[7:5])
			3'h0: `CHK(o_fsm_view, 8'h55, "checker")
			3'h1: `CHK(o_fsm_view, i_core_band, "core band")
			3'h5: `CHK(o_fsm_view, i_temp_adc, "temp")
			default: ;
		endcase
	endtask

	task automatic tally_and_finish();
		if (mismatches == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// scenarios
	initial
	begin
		repeat (40000) @(posedge i_clock);
		mismatches++;
		tally_and_finish();
	end

	initial
	begin
		void'($urandom(32'h0bf5));
		do_reset();
		foreach (ofs[j]) rchk(ofs[j]);
		cchk();
		for (int i = 0; i < 16; i++)
		begin
			i_core_band <= 8'($urandom);
			i_temp_adc <= 8'($urandom);
			foreach (ofs[j]) wreg(ofs[j], 8'($urandom));
			wreg(OFS_READBACK_SEL_LOCK_WAIT, {i[2:0], 5'($urandom)});
			wreg(OFS_CAL_TEST_MODE, {i[2:0], 5'h00});
			wreg(9'h0_35, 8'($urandom));
			cchk();
			foreach (ofs[j]) rchk(ofs[j]);
			rchk(9'h0_35);
			rchk(9'h0_21);
		end
		// lock count per code, lock-loss enable alternating
		wreg(OFS_LOCK_WINDOW_BLEED_CTRL, 8'h18);
		for (int c = 0; c < 4; c++)
		begin
			wreg(OFS_LOCK_COUNT_CTRL, {5'h00, c[1:0], c[0]});
			pulse(1, 1'b0);
			pulse((1024 << c) - 1, 1'b1);
			tick(2);
			`CHK(o_lock, 1'b0, "lock early")
			`CHK(o_ctrl.pump_offset_active, 1'b0, "gated off")
			pulse(1, 1'b1);
			tick(2);
			`CHK(o_lock, 1'b1, "lock")
			`CHK(o_ctrl.pump_offset_active, 1'b1, "gated on")
			i_ref_present <= 1'b0;
			tick(3);
			`CHK(o_lock, ~c[0], "ref loss")
			i_ref_present <= 1'b1;
			pulse(1, 1'b0);
			tick(2);
			`CHK(o_lock, 1'b0, "out of window")
		end
		// update event, direct and reference aligned
		wreg(OFS_BLEED_POLARITY_SYNC, 8'h00);
		tick(4);
		strobes = 0;
		aligned = 0;
		wreg(OFS_CAL_TEST_MODE, 8'h80);
		tick(4);
		`CHK(strobes, 1, "update now")
		`CHK(aligned, 1, "aligned copy now")
		wreg(OFS_BLEED_POLARITY_SYNC, 8'h08);
		strobes = 0;
		aligned = 0;
		wreg(OFS_CAL_TEST_MODE, 8'h40);
		tick(6);
		`CHK(strobes, 0, "update held")
		`CHK(aligned, 0, "aligned copy held")
		i_ref_edge <= 1'b1;
		tick(1);
		i_ref_edge <= 1'b0;
		tick(3);
		`CHK(strobes, 1, "update on edge")
		`CHK(aligned, 1, "aligned copy on edge")
		// mask clear on integer word update
		for (int e = 0; e < 2; e++)
		begin
			wreg(OFS_MODULATOR_CTRL, {5'h00, e[0], 2'h0});
			clears = 0;
			i_int_word_update <= 1'b1;
			tick(1);
			i_int_word_update <= 1'b0;
			tick(4);
			`CHK(clears, e, "mask clear")
		end
		do_reset();
		foreach (ofs[j]) rchk(ofs[j]);
		cchk();
		tally_and_finish();
	end
endmodule
